//--- hw/ebet_cmp.sv
// Masked address, data and cycle status comparator.
// Assumes bus inputs describe one completed bus cycle when valid.
`timescale 1ns/100ps
module ebet_cmp
	import ebet_pkg::*;
(
	input wire logic [EBET_PAT_W-1:0] value_i,
	input wire logic [EBET_PAT_W-1:0] care_i,
	input wire logic [11:0] addr_i,
	input wire logic [7:0] data_i,
	input wire logic [EBET_ST_W-1:0] status_i,
	input wire logic use_data_i,
	output logic hit_o
);
	import ebet_pkg::*;

	// Address and data bits with care low are don't-care; status matches if any selected kind occurs
	wire [11:0] addr_diff = (addr_i ^ value_i[11:0]) & care_i[11:0];
	wire [7:0] data_diff = (data_i ^ value_i[EBET_PAT_ST_LSB-1:EBET_PAT_DATA_LSB])
		& care_i[EBET_PAT_ST_LSB-1:EBET_PAT_DATA_LSB];
	wire [EBET_ST_W-1:0] st_sel = value_i[EBET_PAT_W-1:EBET_PAT_ST_LSB];
	wire st_hit = (st_sel == '0) || ((st_sel & status_i) != '0);
	assign hit_o = (addr_diff == '0) && st_hit && (!use_data_i || data_diff == '0);
endmodule // ebet_cmp

//--- hw/ebet_pkg.sv
// Package of constants and types for the emulator break, event and trace block.
// Assumes one emulation clock; all bus inputs are synchronous to it.
// How it works
// - Four-mode map per 256-byte page.
// - Three break comparators plus event, each enabled.
// - Break comparators qualify on cycle status.
// - Armed breaks wait for prior event trigger.
// - Event comparator also matches masked data.
// - Event match pulses output, emulation continues.
// - Event match optionally acts as break.
// - External break on chosen edge, TTL driven.
// - Eight software points, one collective enable.
// - Every emulated cycle written to trace store.
// - Manual monitor break ends emulation anytime.
// - In-monitor flag set outside emulation only.
// - Halted flag on halt or bus grant.
package ebet_pkg;

	// ****************************************************************
	// Register map (word aligned byte offsets)
	// ****************************************************************
	localparam logic [7:0] EBET_OFS_CTRL = 8'h00;
	localparam logic [7:0] EBET_OFS_STATUS = 8'h04;
	localparam logic [7:0] EBET_OFS_CMP_A = 8'h10;
	localparam logic [7:0] EBET_OFS_CMP_B = 8'h14;
	localparam logic [7:0] EBET_OFS_CMP_C = 8'h18;
	localparam logic [7:0] EBET_OFS_CMP_E = 8'h1c;
	localparam logic [7:0] EBET_OFS_MASK_A = 8'h20;
	localparam logic [7:0] EBET_OFS_MASK_B = 8'h24;
	localparam logic [7:0] EBET_OFS_MASK_C = 8'h28;
	localparam logic [7:0] EBET_OFS_MASK_E = 8'h2c;
	localparam logic [7:0] EBET_OFS_SWBP_BASE = 8'h40;
	localparam logic [7:0] EBET_OFS_MAP_BASE = 8'h60;
	localparam logic [7:0] EBET_OFS_TRACE_PTR = 8'h70;
	localparam logic [7:0] EBET_OFS_TRACE_DATA = 8'h74;

	// ****************************************************************
	// Control register fields
	// ****************************************************************
	localparam int EBET_CTRL_GO = 0;
	localparam int EBET_CTRL_MANBRK = 1;
	localparam int EBET_CTRL_EN_A = 2;
	localparam int EBET_CTRL_EN_B = 3;
	localparam int EBET_CTRL_EN_C = 4;
	localparam int EBET_CTRL_EN_E = 5;
	localparam int EBET_CTRL_ARM = 6;
	localparam int EBET_CTRL_EVBRK = 7;
	localparam int EBET_CTRL_SWEN = 8;
	localparam int EBET_CTRL_EXTEN = 9;
	localparam int EBET_CTRL_EXTRISE = 10;
	localparam int EBET_CTRL_W = 11;
	localparam logic [EBET_CTRL_W-1:0] EBET_CTRL_RST = 11'h000;

	// Comparator pattern layout: value/care for addr [11:0], data [19:12], status [26:20]
	localparam int EBET_ST_W = 7;
	localparam int EBET_PAT_DATA_LSB = 12;
	localparam int EBET_PAT_ST_LSB = 20;
	localparam int EBET_PAT_W = 27;
	localparam logic [EBET_PAT_W-1:0] EBET_PAT_RST = 27'h0000000;

	// Status selector bits, one per selectable cycle kind
	localparam int EBET_ST_FETCH = 0;
	localparam int EBET_ST_MEM_ANY = 1;
	localparam int EBET_ST_MEM_RD = 2;
	localparam int EBET_ST_MEM_WR = 3;
	localparam int EBET_ST_PORT_ANY = 4;
	localparam int EBET_ST_PORT_RD = 5;
	localparam int EBET_ST_PORT_WR = 6;

	// Status register fields
	localparam int EBET_STS_MON = 0;
	localparam int EBET_STS_HALT = 1;
	localparam int EBET_STS_CAUSE_LSB = 4;
	localparam int EBET_CAUSE_W = 4;

	// ****************************************************************
	// Memory map and trace geometry
	// ****************************************************************
	localparam int EBET_PAGE_BITS = 8;
	localparam int EBET_PAGES = 16;
	localparam int EBET_SWBP = 8;
	localparam int EBET_TRACE_AW = 11;
	localparam int EBET_TRACE_W = 32;

	typedef enum logic [1:0] {
		EBET_MAP_USER,
		EBET_MAP_EMU_RW,
		EBET_MAP_EMU_RO,
		EBET_MAP_NONE
	} ebet_map_t;
	localparam logic [1:0] EBET_MAP_RST = 2'h0;

	// Break causes reported in status
	typedef enum logic [3:0] {
		EBET_CAUSE_NONE,
		EBET_CAUSE_HW,
		EBET_CAUSE_EVENT,
		EBET_CAUSE_SW,
		EBET_CAUSE_EXT,
		EBET_CAUSE_ILLEGAL,
		EBET_CAUSE_MANUAL
	} ebet_cause_t;

endpackage

//--- hw/ebet_top.sv
// Break, event trigger, memory map and real-time trace for an in-circuit emulator.
// Assumes the emulated CPU presents one cycle per cyc_valid_i pulse and stops when
// emu_run_o falls; registers reached over Avalon-MM with waitrequest.
//
// The register addresses and register access over Avalon-MM were decided locally.
`timescale 1ns/100ps
module ebet_top (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	// Avalon-MM slave
	input wire logic [7:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	// Emulated CPU bus
	input wire logic cyc_valid_i,
	input wire logic [11:0] cyc_addr_i,
	input wire logic [7:0] cyc_data_i,
	input wire logic cyc_prog_i,
	input wire logic cyc_rd_i,
	input wire logic cyc_wr_i,
	input wire logic cyc_port_i,
	input wire logic cpu_halted_i,
	input wire logic bus_grant_acknowledge_i,
	input wire logic ext_break_i,
	input wire logic monitor_break_i,
	// Outputs
	output logic emu_run_o,
	output logic in_monitor_o,
	output logic halted_o,
	output logic event_trig_o,
	output logic illegal_o,
	output logic [1:0] page_mode_o
);
	import ebet_pkg::*;

	// ****************************************************************
	// Registers
	// ****************************************************************
	logic [EBET_CTRL_W-1:0] ctrl_reg;
	logic [EBET_PAT_W-1:0] value_reg [4];
	logic [EBET_PAT_W-1:0] care_reg [4];
	logic [11:0] swbp_reg [EBET_SWBP];
	logic [1:0] map_reg [EBET_PAGES];
	logic [EBET_TRACE_W-1:0] trace_mem [2**EBET_TRACE_AW];
	logic [EBET_TRACE_AW-1:0] trace_wp_reg;
	logic [EBET_TRACE_AW-1:0] trace_rp_reg;
	logic trace_wrap_reg;
	logic run_reg;
	logic mon_reg;
	logic armed_reg;
	logic ext_prev_reg;
	logic [EBET_CAUSE_W-1:0] cause_reg;
	logic [31:0] rdata_reg;
	logic wait_reg;
	logic event_reg;
	logic illegal_reg;
	logic halted_reg;
	logic [1:0] page_mode_reg;

	// ****************************************************************
	// Comparators
	// ****************************************************************
	wire [EBET_ST_W-1:0] cyc_status;
	wire [3:0] cmp_hit;
	wire mem_cyc = !cyc_prog_i && !cyc_port_i && (cyc_rd_i || cyc_wr_i);
	assign cyc_status[EBET_ST_FETCH] = cyc_prog_i && cyc_rd_i;
	assign cyc_status[EBET_ST_MEM_ANY] = mem_cyc;
	assign cyc_status[EBET_ST_MEM_RD] = mem_cyc && cyc_rd_i;
	assign cyc_status[EBET_ST_MEM_WR] = mem_cyc && cyc_wr_i;
	assign cyc_status[EBET_ST_PORT_ANY] = cyc_port_i;
	assign cyc_status[EBET_ST_PORT_RD] = cyc_port_i && cyc_rd_i;
	assign cyc_status[EBET_ST_PORT_WR] = cyc_port_i && cyc_wr_i;

	// one comparator per break A, B, C and event
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_cmp
			ebet_cmp u_cmp (
				.value_i(value_reg[gi]),
				.care_i(care_reg[gi]),
				.addr_i(cyc_addr_i),
				.data_i(cyc_data_i),
				.status_i(cyc_status),
				.use_data_i(gi == 3),
				.hit_o(cmp_hit[gi])
			);
		end
	endgenerate

	// ****************************************************************
	// Break decision
	// ****************************************************************
	// Bus strobes count once, in the first cycle of a request
	wire bus_wr = avs_write_i && wait_reg;
	wire bus_rd = avs_read_i && wait_reg;
	wire ctrl_sel = avs_address_i == EBET_OFS_CTRL;
	wire emu_cyc = run_reg && cyc_valid_i;
	wire hw_raw = (cmp_hit[0] && ctrl_reg[EBET_CTRL_EN_A])
		|| (cmp_hit[1] && ctrl_reg[EBET_CTRL_EN_B])
		|| (cmp_hit[2] && ctrl_reg[EBET_CTRL_EN_C]);
	wire ev_hit = emu_cyc && cmp_hit[3] && ctrl_reg[EBET_CTRL_EN_E];
	// arming gates hardware matches until event seen
	wire hw_brk = emu_cyc && hw_raw && (!ctrl_reg[EBET_CTRL_ARM] || armed_reg);
	wire ev_brk = ev_hit && ctrl_reg[EBET_CTRL_EVBRK];
	logic sw_any;
	always_comb begin
		sw_any = 1'b0;
		for (int i = 0; i < EBET_SWBP; i++) begin
			if (swbp_reg[i] == cyc_addr_i) begin
				sw_any = 1'b1;
			end
		end
	end
	wire sw_brk = emu_cyc && cyc_prog_i && cyc_rd_i && ctrl_reg[EBET_CTRL_SWEN] && sw_any;
	// edge select on the external break input
	wire ext_edge = ctrl_reg[EBET_CTRL_EXTRISE] ? (ext_break_i && !ext_prev_reg)
		: (!ext_break_i && ext_prev_reg);
	wire ext_brk = run_reg && ctrl_reg[EBET_CTRL_EXTEN] && ext_edge;
	// page lookup; no-memory pages flag illegal access
	wire [3:0] page_idx = cyc_addr_i[11:EBET_PAGE_BITS];
	wire [1:0] page_mode = map_reg[page_idx];
	wire ill_brk = emu_cyc && (cyc_rd_i || cyc_wr_i) && !cyc_port_i
		&& (page_mode == EBET_MAP_NONE);
	// manual break from the switch or software
	wire man_brk = run_reg && (monitor_break_i
		|| (bus_wr && ctrl_sel && avs_writedata_i[EBET_CTRL_MANBRK]));
	wire any_brk = hw_brk || ev_brk || sw_brk || ext_brk || ill_brk || man_brk;
	wire [EBET_CAUSE_W-1:0] cause_next = man_brk ? EBET_CAUSE_MANUAL
		: ill_brk ? EBET_CAUSE_ILLEGAL
		: hw_brk ? EBET_CAUSE_HW
		: ev_brk ? EBET_CAUSE_EVENT
		: sw_brk ? EBET_CAUSE_SW
		: EBET_CAUSE_EXT;

	// ****************************************************************
	// Bus decode
	// ****************************************************************
	wire go_req = bus_wr && ctrl_sel && avs_writedata_i[EBET_CTRL_GO] && !run_reg;
	wire [1:0] cmp_idx = avs_address_i[3:2];
	wire cmp_val_sel = avs_address_i[7:4] == EBET_OFS_CMP_A[7:4];
	wire cmp_care_sel = avs_address_i[7:4] == EBET_OFS_MASK_A[7:4];
	wire swbp_sel = avs_address_i[7:5] == EBET_OFS_SWBP_BASE[7:5];
	wire map_sel = avs_address_i[7:4] == EBET_OFS_MAP_BASE[7:4];
	wire [2:0] swbp_idx = avs_address_i[4:2];
	wire [1:0] map_grp = avs_address_i[3:2];
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h00000000;
		if (ctrl_sel) begin
			rd_mux = {21'h000000, ctrl_reg};
		end else if (avs_address_i == EBET_OFS_STATUS) begin
			rd_mux = {24'h000000, cause_reg, 2'h0, halted_reg, mon_reg};
		end else if (cmp_val_sel) begin
			rd_mux = {5'h00, value_reg[cmp_idx]};
		end else if (cmp_care_sel) begin
			rd_mux = {5'h00, care_reg[cmp_idx]};
		end else if (swbp_sel) begin
			rd_mux = {20'h00000, swbp_reg[swbp_idx]};
		end else if (map_sel) begin
			rd_mux = {24'h000000, map_reg[{map_grp, 2'h3}], map_reg[{map_grp, 2'h2}],
				map_reg[{map_grp, 2'h1}], map_reg[{map_grp, 2'h0}]};
		end else if (avs_address_i == EBET_OFS_TRACE_PTR) begin
			rd_mux = {5'h00, trace_rp_reg, 4'h0, trace_wrap_reg, trace_wp_reg};
		end else if (avs_address_i == EBET_OFS_TRACE_DATA) begin
			rd_mux = trace_mem[trace_rp_reg];
		end
	end

	// ****************************************************************
	// Trace store
	// ****************************************************************
	// one entry per emulated cycle; layout from bit 0 addr, data, space, strobes, port
	wire [EBET_TRACE_W-1:0] trace_word = {7'h00, cyc_port_i, cyc_wr_i, cyc_rd_i,
		!cyc_prog_i, cyc_prog_i, cyc_data_i, cyc_addr_i};
	always_ff @(posedge clk_sys_i) begin
		if (emu_cyc) begin
			trace_mem[trace_wp_reg] <= trace_word;
		end
	end

	// ****************************************************************
	// Configuration registers
	// ****************************************************************
	// Patterns, points and map live in arrays without reset need beyond zero
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			for (int i = 0; i < 4; i++) begin
				value_reg[i] <= EBET_PAT_RST;
				care_reg[i] <= EBET_PAT_RST;
			end
			for (int i = 0; i < EBET_SWBP; i++) begin
				swbp_reg[i] <= 12'h000;
			end
			for (int i = 0; i < EBET_PAGES; i++) begin
				map_reg[i] <= EBET_MAP_RST;
			end
		end else if (bus_wr) begin
			if (cmp_val_sel) begin
				value_reg[cmp_idx] <= avs_writedata_i[EBET_PAT_W-1:0];
			end
			if (cmp_care_sel) begin
				care_reg[cmp_idx] <= avs_writedata_i[EBET_PAT_W-1:0];
			end
			if (swbp_sel) begin
				swbp_reg[swbp_idx] <= avs_writedata_i[11:0];
			end
			// four pages per word, two mode bits each
			if (map_sel) begin
				for (int i = 0; i < 4; i++) begin
					map_reg[{map_grp, 2'(i)}] <= avs_writedata_i[2*i +: 2];
				end
			end
		end
	end

	// ****************************************************************
	// Run control and outputs
	// ****************************************************************
	// Manual break and go bits self-clear; only enable and mode bits are stored
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			ctrl_reg <= EBET_CTRL_RST;
			run_reg <= 1'b0;
			mon_reg <= 1'b1;
			armed_reg <= 1'b0;
			ext_prev_reg <= 1'b0;
			cause_reg <= EBET_CAUSE_NONE;
			trace_wp_reg <= '0;
			trace_rp_reg <= '0;
			trace_wrap_reg <= 1'b0;
			rdata_reg <= 32'h00000000;
			wait_reg <= 1'b1;
			event_reg <= 1'b0;
			illegal_reg <= 1'b0;
			halted_reg <= 1'b0;
			page_mode_reg <= EBET_MAP_RST;
		end else begin
			ext_prev_reg <= ext_break_i;
			wait_reg <= !((avs_read_i || avs_write_i) && wait_reg);
			if (bus_rd) begin
				rdata_reg <= rd_mux;
			end
			if (bus_wr && ctrl_sel) begin
				ctrl_reg <= avs_writedata_i[EBET_CTRL_W-1:0] & 11'h7fc;
			end
			if (bus_wr && avs_address_i == EBET_OFS_TRACE_PTR) begin
				trace_rp_reg <= avs_writedata_i[16 +: EBET_TRACE_AW];
			end
			// stop at end of the matching cycle; break beats go
			if (any_brk) begin
				run_reg <= 1'b0;
				mon_reg <= 1'b1;
				cause_reg <= cause_next;
			end else if (go_req) begin
				run_reg <= 1'b1;
				mon_reg <= 1'b0;
				armed_reg <= 1'b0;
				trace_wp_reg <= '0;
				trace_wrap_reg <= 1'b0;
			end
			if (ev_hit) begin
				armed_reg <= 1'b1;
			end
			if (emu_cyc) begin
				trace_wp_reg <= trace_wp_reg + 1'b1;
				if (&trace_wp_reg) begin
					trace_wrap_reg <= 1'b1;
				end
			end
			event_reg <= ev_hit;
			illegal_reg <= ill_brk;
			halted_reg <= cpu_halted_i || bus_grant_acknowledge_i;
			page_mode_reg <= page_mode;
		end
	end

	assign avs_readdata_o = rdata_reg;
	assign avs_waitrequest_o = wait_reg;
	assign emu_run_o = run_reg;
	// monitor flag has its own flop, set and cleared opposite to run
	assign in_monitor_o = mon_reg;
	assign halted_o = halted_reg;
	assign event_trig_o = event_reg;
	assign illegal_o = illegal_reg;
	assign page_mode_o = page_mode_reg;

	// ****************************************************************
	// Assertions
	// ****************************************************************
	property p_evpulse;
		@(posedge clk_sys_i) disable iff (rst_i)
		ev_hit |=> event_trig_o && (emu_run_o || $past(any_brk));
	endproperty
	a_evpulse: assert property (p_evpulse) else $error("event pulse missing");
	property p_evbrk;
		@(posedge clk_sys_i) disable iff (rst_i)
		ev_brk |=> !emu_run_o;
	endproperty
	a_evbrk: assert property (p_evbrk) else $error("event break ignored");
	property p_arm;
		@(posedge clk_sys_i) disable iff (rst_i)
		emu_cyc && ctrl_reg[EBET_CTRL_ARM] && !armed_reg && !any_brk |=> emu_run_o;
	endproperty
	a_arm: assert property (p_arm) else $error("unarmed break stopped");
	property p_ill;
		@(posedge clk_sys_i) disable iff (rst_i)
		emu_cyc && cyc_rd_i && !cyc_port_i && page_mode == EBET_MAP_NONE
			|=> illegal_o && !emu_run_o;
	endproperty
	a_ill: assert property (p_ill) else $error("illegal access missed");
	property p_man;
		@(posedge clk_sys_i) disable iff (rst_i)
		emu_run_o && monitor_break_i |=> in_monitor_o;
	endproperty
	a_man: assert property (p_man) else $error("manual break missed");
	property p_mon;
		@(posedge clk_sys_i) disable iff (rst_i)
		in_monitor_o != emu_run_o;
	endproperty
	a_mon: assert property (p_mon) else $error("monitor flag wrong");
	property p_halt;
		@(posedge clk_sys_i) disable iff (rst_i)
		bus_grant_acknowledge_i |=> halted_o;
	endproperty
	a_halt: assert property (p_halt) else $error("halt flag missing");
	property p_ext;
		@(posedge clk_sys_i) disable iff (rst_i)
		emu_run_o && ctrl_reg[EBET_CTRL_EXTEN] && ctrl_reg[EBET_CTRL_EXTRISE]
			&& ext_break_i && !$past(ext_break_i) |=> !emu_run_o;
	endproperty
	a_ext: assert property (p_ext) else $error("external edge missed");
	property p_trace;
		@(posedge clk_sys_i) disable iff (rst_i)
		emu_cyc && !go_req |=> trace_wp_reg == $past(trace_wp_reg) + 11'h001;
	endproperty
	a_trace: assert property (p_trace) else $error("trace pointer stuck");
	property p_sw;
		@(posedge clk_sys_i) disable iff (rst_i)
		emu_cyc && cyc_prog_i && cyc_rd_i && !ctrl_reg[EBET_CTRL_SWEN] && !hw_brk
			&& !ev_brk && !ext_brk && !ill_brk && !man_brk |=> emu_run_o;
	endproperty
	a_sw: assert property (p_sw) else $error("disabled point stopped");
	c_run: cover property (@(posedge clk_sys_i) go_req ##[1:20] !emu_run_o);
	c_ev: cover property (@(posedge clk_sys_i) event_trig_o && emu_run_o);
	c_sw: cover property (@(posedge clk_sys_i) sw_brk);
endmodule // ebet_top

//--- verif/ebet_cpu_model.sv
// Behavioural emulated CPU bus and external break line facing the break block.
// Assumes its tasks are called just after a rising clk_sys_i edge.
`timescale 1ns/100ps
module ebet_cpu_model (
	input wire logic clk_sys_i,
	input wire logic emu_run_i,
	output logic cyc_valid_o,
	output logic [11:0] cyc_addr_o,
	output logic [7:0] cyc_data_o,
	output logic cyc_prog_o,
	output logic cyc_rd_o,
	output logic cyc_wr_o,
	output logic cyc_port_o,
	output logic ext_break_o
);
	// ****
	// Bus cycles
	// ****
	// Idle bus at time zero
	initial begin
		cyc_valid_o = 1'b0;
		cyc_addr_o = 12'h000;
		cyc_data_o = 8'h00;
		cyc_prog_o = 1'b0;
		cyc_rd_o = 1'b0;
		cyc_wr_o = 1'b0;
		cyc_port_o = 1'b0;
		ext_break_o = 1'b0;
	end

	// Kind 0 fetch, 1 data rd, 2 data wr, 3 port rd, 4 port wr; a stopped CPU issues none
	task automatic cycle(input int kind, input logic [11:0] addr, input logic [7:0] data,
		input int gap);
		repeat (gap + 1) @(posedge clk_sys_i);
		if (emu_run_i === 1'b1) begin
			cyc_valid_o <= 1'b1;
			cyc_addr_o <= addr;
			cyc_data_o <= data;
			cyc_prog_o <= (kind == 0);
			cyc_rd_o <= (kind == 0) || (kind == 1) || (kind == 3);
			cyc_wr_o <= (kind == 2) || (kind == 4);
			cyc_port_o <= (kind >= 3);
			@(posedge clk_sys_i);
			// Released address and data lines flip, so a stale value cannot match a pattern
			cyc_valid_o <= 1'b0;
			cyc_addr_o <= ~addr;
			cyc_data_o <= ~data;
			cyc_prog_o <= 1'b0;
			cyc_rd_o <= 1'b0;
			cyc_wr_o <= 1'b0;
			cyc_port_o <= 1'b0;
		end
	endtask

	// ****
	// External break line
	// ****
	// clean logic levels
	task automatic ext_level(input logic lvl);
		@(posedge clk_sys_i);
		ext_break_o <= lvl;
	endtask

endmodule // ebet_cpu_model

//--- verif/ebet_top_tb.sv
// Self-checking bench for the break, event, map and trace block.
// Assumes the CPU bus model in ebet_cpu_model and a 25 ns clock.
`timescale 1ns/100ps
module ebet_top_tb;
	import ebet_pkg::*;
	logic clk_sys_i = 1'b0;
	logic rst_i = 1'b1;
	logic [7:0] avs_address_i = 8'h00;
	logic avs_read_i = 1'b0;
	logic avs_write_i = 1'b0;
	logic [31:0] avs_writedata_i = 32'h00000000;
	logic cpu_halted_i = 1'b0;
	logic bus_grant_acknowledge_i = 1'b0;
	logic monitor_break_i = 1'b0;
	logic [31:0] avs_readdata_o;
	logic avs_waitrequest_o, cyc_valid_i, cyc_prog_i, cyc_rd_i, cyc_wr_i, cyc_port_i, ext_break_i;
	logic emu_run_o, in_monitor_o, halted_o, event_trig_o, illegal_o;
	logic [11:0] cyc_addr_i, a;
	logic [7:0] cyc_data_i, d;
	logic [1:0] page_mode_o;
	logic [31:0] exp_q[$];
	logic [31:0] tw[3];
	int miscompares = 0;
	int comparisons = 0;
	int ev_count = 0;
	int il_count = 0;
	int k;
	int hit[7] = '{0, 2, 1, 2, 4, 3, 4};
	int nok[7] = '{1, 3, 2, 1, 0, 4, 3};
	int pg[3] = '{4, 6, 7};

	ebet_top dut_u (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
		.avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
		.avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
		.cyc_valid_i(cyc_valid_i), .cyc_addr_i(cyc_addr_i), .cyc_data_i(cyc_data_i),
		.cyc_prog_i(cyc_prog_i), .cyc_rd_i(cyc_rd_i), .cyc_wr_i(cyc_wr_i),
		.cyc_port_i(cyc_port_i), .cpu_halted_i(cpu_halted_i),
		.bus_grant_acknowledge_i(bus_grant_acknowledge_i), .ext_break_i(ext_break_i),
		.monitor_break_i(monitor_break_i), .emu_run_o(emu_run_o), .in_monitor_o(in_monitor_o),
		.halted_o(halted_o), .event_trig_o(event_trig_o), .illegal_o(illegal_o),
		.page_mode_o(page_mode_o));

	ebet_cpu_model cpu_u (.clk_sys_i(clk_sys_i), .emu_run_i(emu_run_o),
		.cyc_valid_o(cyc_valid_i), .cyc_addr_o(cyc_addr_i), .cyc_data_o(cyc_data_i),
		.cyc_prog_o(cyc_prog_i), .cyc_rd_o(cyc_rd_i), .cyc_wr_o(cyc_wr_i),
		.cyc_port_o(cyc_port_i), .ext_break_o(ext_break_i));

	// ****
	// Helpers
	// ****
	// Free-running clock
	initial begin
		forever #12.5 clk_sys_i = ~clk_sys_i;
	end

	function automatic logic [31:0] b(input int i);
		return 32'h1 << i;
	endfunction

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Request held until waitrequest is seen low at an edge
	task automatic bus(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge clk_sys_i);
		avs_address_i <= ad;
		avs_writedata_i <= wd;
		avs_write_i <= wr;
		avs_read_i <= !wr;
		do begin
			@(posedge clk_sys_i);
			n++;
		end while (avs_waitrequest_o !== 1'b0 && n < 20);
		if (n >= 20) chk("waitrequest", 32'h0, 32'h1);
		avs_write_i <= 1'b0;
		avs_read_i <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] ad, input logic [31:0] e);
		exp_q.push_back(e);
		bus(1'b0, ad, 32'h0);
	endtask

	// Same one-hot status select in value and care, whichever the comparator reads
	task automatic pat(input int i, input logic [11:0] pa, input logic [7:0] pd,
		input logic [6:0] s, input logic [7:0] dc);
		bus(1'b1, 8'(EBET_OFS_CMP_A + 8'(4 * i)), {5'h0, s, pd, pa});
		bus(1'b1, 8'(EBET_OFS_MASK_A + 8'(4 * i)), {5'h0, s, dc, 12'hfff});
	endtask

	task automatic cyc(input int kind, input logic [11:0] ca, input logic [7:0] cd);
		cpu_u.cycle(kind, ca, cd, $urandom_range(2));
	endtask

	task automatic go(input logic [31:0] en);
		bus(1'b1, EBET_OFS_CTRL, en | b(EBET_CTRL_GO));
		repeat (3) @(posedge clk_sys_i);
		chk("emu_run_o", 32'h1, {31'h0, emu_run_o});
		chk("in_monitor_o", 32'h0, {31'h0, in_monitor_o});
	endtask

	task automatic ok();
		repeat (3) @(posedge clk_sys_i);
		chk("emu_run_o", 32'h1, {31'h0, emu_run_o});
	endtask

	task automatic brk(input logic [3:0] c);
		repeat (3) @(posedge clk_sys_i);
		chk("emu_run_o", 32'h0, {31'h0, emu_run_o});
		chk("in_monitor_o", 32'h1, {31'h0, in_monitor_o});
		rd(EBET_OFS_STATUS, {24'h0, c, 4'h1});
	endtask

	task automatic stop_test();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// Read answers popped in order; output pulses counted per cycle
	always @(posedge clk_sys_i) begin
		if (avs_read_i === 1'b1 && avs_waitrequest_o === 1'b0) begin
			chk("avs_readdata_o", exp_q.pop_front(), avs_readdata_o);
		end
		if (event_trig_o === 1'b1) ev_count++;
		if (illegal_o === 1'b1) il_count++;
	end

	// Watchdog well beyond the expected run length
	initial begin
		#1000000;
		chk("watchdog", 32'h0, 32'h1);
		stop_test();
	end

	// ****
	// Scenarios
	// ****
	initial begin
		void'($urandom(32'hcb4a511b));
		repeat (20) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		@(posedge clk_sys_i);
		chk("in_monitor_o", 32'h1, {31'h0, in_monitor_o});
		rd(EBET_OFS_CTRL, 32'h0);
		rd(8'h80, 32'h0);
		cpu_halted_i <= 1'b1;
		repeat (3) @(posedge clk_sys_i);
		rd(EBET_OFS_STATUS, 32'h3);
		cpu_halted_i <= 1'b0;
		bus_grant_acknowledge_i <= 1'b1;
		repeat (3) @(posedge clk_sys_i);
		chk("halted_o", 32'h1, {31'h0, halted_o});
		bus_grant_acknowledge_i <= 1'b0;
		repeat (3) @(posedge clk_sys_i);
		chk("halted_o", 32'h0, {31'h0, halted_o});
		// Trace of three random cycles, then pin break and read back
		go(32'h0);
		for (int i = 0; i < 3; i++) begin
			a = 12'($urandom_range(255)) + 12'h010;
			d = 8'($urandom);
			k = i * 2;
			tw[i] = {7'h0, k == 4, k != 0, k == 0, k != 0, k == 0, d, a};
			cyc(k, a, d);
		end
		monitor_break_i <= 1'b1;
		@(posedge clk_sys_i);
		monitor_break_i <= 1'b0;
		brk(4'h6);
		bus(1'b1, EBET_OFS_TRACE_PTR, 32'h0);
		rd(EBET_OFS_TRACE_PTR, 32'h3);
		for (int i = 0; i < 3; i++) begin
			bus(1'b1, EBET_OFS_TRACE_PTR, 32'(i) << 16);
			rd(EBET_OFS_TRACE_DATA, tw[i]);
		end
		// Every status select over comparators A, B and C
		for (int s = 0; s < 7; s++) begin
			pat(s % 3, 12'h123, 8'h00, 7'(1 << s), 8'h00);
			go(b(EBET_CTRL_EN_A + s % 3));
			cyc(nok[s], 12'h123, 8'h00);
			cyc(hit[s], 12'h122, 8'h00);
			ok();
			cyc(hit[s], 12'h123, 8'h00);
			brk(4'h1);
		end
		// Event on address, data and write status
		pat(3, 12'h200, 8'h5a, 7'h08, 8'hff);
		go(b(EBET_CTRL_EN_E));
		cyc(2, 12'h200, 8'h5b);
		cyc(1, 12'h200, 8'h5a);
		cyc(2, 12'h200, 8'h5a);
		ok();
		chk("event pulses", 32'h1, 32'(ev_count));
		go(b(EBET_CTRL_EN_E) | b(EBET_CTRL_EVBRK));
		cyc(2, 12'h200, 8'h5a);
		brk(4'h2);
		// Armed break ignores hits before the event
		pat(0, 12'h123, 8'h00, 7'h01, 8'h00);
		go(b(EBET_CTRL_EN_A) | b(EBET_CTRL_EN_E) | b(EBET_CTRL_ARM));
		cyc(0, 12'h123, 8'h00);
		ok();
		cyc(2, 12'h200, 8'h5a);
		cyc(0, 12'h123, 8'h00);
		brk(4'h1);
		chk("event pulses", 32'h3, 32'(ev_count));
		// Software points: collective enable, then each point
		for (int i = 0; i < 8; i++) bus(1'b1, 8'(EBET_OFS_SWBP_BASE + 8'(4 * i)), 32'h0a0 + i);
		go(32'h0);
		cyc(0, 12'h0a3, 8'h00);
		ok();
		bus(1'b1, EBET_OFS_CTRL, b(EBET_CTRL_MANBRK));
		brk(4'h6);
		for (int i = 0; i < 8; i++) begin
			go(b(EBET_CTRL_SWEN));
			cyc(1, 12'h0a0 + 12'(i), 8'h00);
			ok();
			cyc(0, 12'h0a0 + 12'(i), 8'h00);
			brk(4'h3);
		end
		// External break on each edge choice
		go(b(EBET_CTRL_EXTEN) | b(EBET_CTRL_EXTRISE));
		cpu_u.ext_level(1'b1);
		brk(4'h4);
		cpu_u.ext_level(1'b0);
		go(b(EBET_CTRL_EXTEN));
		cpu_u.ext_level(1'b1);
		ok();
		cpu_u.ext_level(1'b0);
		brk(4'h4);
		// Page modes 0, 3, 1, 2 on pages 4..7, illegal access on the empty page 5
		bus(1'b1, 8'(EBET_OFS_MAP_BASE + 8'h04), 32'h0000009c);
		go(32'h0);
		for (int p = 0; p < 3; p++) begin
			cyc(1, 12'(pg[p] * 256 + 64), 8'h00);
			@(posedge clk_sys_i);
			chk("page_mode_o", 32'(p), {30'h0, page_mode_o});
		end
		cyc(3, 12'h540, 8'h00);
		ok();
		cyc(1, 12'h540, 8'h00);
		brk(4'h5);
		chk("illegal pulses", 32'h1, 32'(il_count));
		stop_test();
	end

endmodule // ebet_top_tb
